// *** rtl/flash_dev.sv ***
// What this block does
// - works with clock modes zero and three
// - samples on rising, drives on falling
// - master idles clock per chosen mode
// - only selected memory drives data out
// - at most 256 bytes within one page
// - latch-set command precedes every page modify
// - opcode, three address bytes, data, deselect
// - data bytes fill buffer from low address
// - deselect starts cycle, merges untouched bytes
// - page write erases then programs page
// - page program only clears ones, no erase
// - master sends consecutive bytes in one burst
// - status holds busy flag for polling
// - master holds reset low during power-up
// - active until internal cycle ends, then standby
// - deep sleep command enters deep power-down
// - deep power-down ignores all but wake
// - modify needs latch; latch clears after
// - reject modify unless bit count multiple eight
// - deselected output stays undriven
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module flash_dev #(
  parameter int NUM_PAGES  = 8192,
  parameter int CYCLE_WAIT = 16
) (
  // link
  flash_spi_if.device bus,
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  // state seen by the system
  output logic      o_busy,
  output logic      o_write_latch,
  output logic      o_active,
  output logic      o_standby,
  output logic      o_deep_sleep
);
  import spi_flash_pkg::*;

  localparam int PAGE_AW = $clog2(NUM_PAGES);
  localparam int MW      = PAGE_AW + 8;

  if (NUM_PAGES < 2 || (1 << PAGE_AW) != NUM_PAGES || PAGE_AW > 16) begin : g_bad_pages
    $error("NUM_PAGES must be a power of two from 2 to 65536");
  end
  if (CYCLE_WAIT < 1 || CYCLE_WAIT > 65535) begin : g_bad_wait
    $error("CYCLE_WAIT must be 1 to 65535");
  end

  // ****************************************
  // pin sampling
  // ****************************************
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  pin_sync3 #(.WIDTH(4), .RESET_VAL(4'hc)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pin     ({bus.reset_n, bus.cs_n, bus.sclk, bus.mosi}),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  logic clr;
  logic cs_n_l;
  logic cs_rise;
  logic cs_fall;
  logic sck_r;
  logic sck_f;
  logic mosi_l;

  assign clr     = !i_reset_n || !pin_lvl[3];
  assign cs_n_l  = pin_lvl[2];
  assign cs_rise = pin_rise[2];
  assign cs_fall = pin_fall[2];
  assign sck_r   = pin_rise[1];
  assign sck_f   = pin_fall[1];
  assign mosi_l  = pin_lvl[0];

  // ****************************************
  // state
  // ****************************************
  logic [2:0]      bit_cnt_ff;
  logic [2:0]      byte_idx_ff;
  logic [6:0]      sh_in_ff;
  logic [7:0]      op_ff;
  logic [23:0]     addr_ff;
  logic [7:0]      tx_ff;
  logic            miso_ff;
  logic            miso_oe_ff;
  logic            latch_ff;
  logic            deep_ff;
  cycle_state_t    state_ff;
  logic [7:0]      sweep_ff;
  logic [15:0]     wait_ff;
  logic [PAGE_AW-1:0] pg_ff;
  logic            kind_write_ff;
  logic [7:0]      buf_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] loaded_ff;
  logic [7:0]      mem_ff [NUM_PAGES*PAGE_BYTES];
  logic [NUM_PAGES-1:0] blank_ff;

  logic [7:0]      byte_in;
  logic            byte_done;
  logic            is_mod_op;
  logic            busy;
  logic [23:0]     rd_addr;
  logic [MW-1:0]   cur_idx;
  logic [7:0]      cur_byte;
  logic [7:0]      status_byte;
  logic            one_byte;
  logic            start_cycle;

  assign byte_in   = {sh_in_ff, mosi_l};
  assign byte_done = sck_r && !cs_n_l && bit_cnt_ff == BIT_LAST;
  assign is_mod_op = op_ff == page_write_cmd || op_ff == page_program_cmd;
  assign busy      = state_ff != CYC_IDLE;
  assign rd_addr   = (byte_idx_ff == BYTE_ADDR_LO) ? {addr_ff[15:0], byte_in} : addr_ff + 24'h1;
  assign cur_idx   = busy ? {pg_ff, sweep_ff} : rd_addr[MW-1:0];
  assign cur_byte  = blank_ff[cur_idx[MW-1:8]] ? ERASED_BYTE : mem_ff[cur_idx];
  assign one_byte  = cs_rise && bit_cnt_ff == '0 && byte_idx_ff == BYTE_ONE;
  // a partial byte at deselect cancels the whole modify request
  assign start_cycle = cs_rise && !busy && is_mod_op && bit_cnt_ff == '0
                       && byte_idx_ff == BYTE_FULL && latch_ff && !deep_ff;

  always_comb begin
    status_byte                 = '0;
    status_byte[STAT_BUSY_BIT]  = busy;
    status_byte[STAT_LATCH_BIT] = latch_ff;
  end

  // ****************************************
  // serial input, mode zero and three alike
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (clr || cs_n_l) begin
      bit_cnt_ff  <= '0;
      byte_idx_ff <= '0;
    end else if (sck_r) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      sh_in_ff   <= byte_in[6:0];
      if (bit_cnt_ff == BIT_LAST) begin
        if (byte_idx_ff != BYTE_FULL) begin
          byte_idx_ff <= byte_idx_ff + 3'h1;
        end
        if (byte_idx_ff == '0) begin
          op_ff <= byte_in;
        end else if (byte_idx_ff < BYTE_DATA) begin
          addr_ff <= {addr_ff[15:0], byte_in};
        end else if (op_ff == read_data_cmd) begin
          addr_ff <= addr_ff + 24'h1;
        end else begin
          addr_ff[7:0] <= addr_ff[7:0] + 8'h1;
        end
      end
    end
  end

  // ****************************************
  // page buffer
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (clr || (cs_fall && !busy)) begin
      loaded_ff <= '0;
    end else if (!busy && byte_done && byte_idx_ff >= BYTE_DATA && is_mod_op && latch_ff && !deep_ff) begin
      buf_ff[addr_ff[7:0]]    <= byte_in;
      loaded_ff[addr_ff[7:0]] <= 1'b1;
    end else if (state_ff == CYC_MERGE && !loaded_ff[sweep_ff]) begin
      // program-only leaves untouched bytes at ones so the and below keeps them
      buf_ff[sweep_ff] <= kind_write_ff ? cur_byte : ERASED_BYTE;
    end
  end

  // ****************************************
  // internal write cycle
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (clr) begin
      state_ff <= CYC_IDLE;
      sweep_ff <= '0;
      wait_ff  <= '0;
    end else begin
      case (state_ff)
        CYC_IDLE: begin
          sweep_ff <= '0;
          if (start_cycle) begin
            state_ff      <= CYC_MERGE;
            pg_ff         <= addr_ff[MW-1:8];
            kind_write_ff <= op_ff == page_write_cmd;
          end
        end
        CYC_MERGE: begin
          sweep_ff <= sweep_ff + 8'h1;
          if (sweep_ff == PAGE_LAST) begin
            state_ff <= kind_write_ff ? CYC_ERASE : CYC_PROG;
          end
        end
        CYC_ERASE: begin
          state_ff <= CYC_PROG;
        end
        CYC_PROG: begin
          sweep_ff <= sweep_ff + 8'h1;
          if (sweep_ff == PAGE_LAST) begin
            state_ff <= CYC_WAIT;
            wait_ff  <= '0;
          end
        end
        CYC_WAIT: begin
          wait_ff <= wait_ff + 16'h1;
          if (wait_ff == 16'(CYCLE_WAIT - 1)) begin
            state_ff <= CYC_IDLE;
          end
        end
        default: begin
          state_ff <= CYC_IDLE;
        end
      endcase
    end
  end

  // array contents survive a pin reset; of the two resets only the system reset marks them blank
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      blank_ff <= '1;
    end else if (state_ff == CYC_ERASE) begin
      blank_ff[pg_ff] <= 1'b1;
    end else if (state_ff == CYC_PROG) begin
      mem_ff[cur_idx] <= kind_write_ff ? buf_ff[sweep_ff] : (cur_byte & buf_ff[sweep_ff]);
      if (sweep_ff == PAGE_LAST) begin
        blank_ff[pg_ff] <= 1'b0;
      end
    end
  end

  // ****************************************
  // write latch and deep power-down
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (clr) begin
      latch_ff <= 1'b0;
      deep_ff  <= 1'b0;
    end else begin
      if (state_ff == CYC_WAIT && wait_ff == 16'(CYCLE_WAIT - 1)) begin
        latch_ff <= 1'b0;
      end else if (one_byte && !deep_ff && !busy && op_ff == write_latch_set_cmd) begin
        latch_ff <= 1'b1;
      end
      if (one_byte && !deep_ff && !busy && op_ff == deep_sleep_cmd) begin
        deep_ff <= 1'b1;
      end else if (one_byte && deep_ff && op_ff == wake_cmd) begin
        deep_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (clr || cs_n_l) begin
      tx_ff <= '0;
    end else if (byte_done) begin
      if (deep_ff) begin
        tx_ff <= '0;
      end else if ((byte_idx_ff == '0 && byte_in == read_status_cmd)
                   || (byte_idx_ff != '0 && op_ff == read_status_cmd)) begin
        tx_ff <= status_byte;
      end else if (byte_idx_ff >= BYTE_ADDR_LO && op_ff == read_data_cmd && !busy) begin
        tx_ff <= cur_byte;
      end else begin
        tx_ff <= '0;
      end
    end else if (sck_f) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr || cs_n_l) begin
      miso_ff <= 1'b0;
    end else if (sck_f) begin
      miso_ff <= tx_ff[7];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    miso_oe_ff <= !clr && !cs_n_l;
  end

  assign bus.miso_out = miso_ff;
  assign bus.miso_oe  = miso_oe_ff;

  // ****************************************
  // power mode and system outputs
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_busy        <= 1'b0;
      o_write_latch <= 1'b0;
      o_active      <= 1'b0;
      o_standby     <= 1'b1;
      o_deep_sleep  <= 1'b0;
    end else begin
      o_busy        <= busy;
      o_write_latch <= latch_ff;
      o_active      <= !cs_n_l || busy;
      o_standby     <= cs_n_l && !busy && !deep_ff;
      o_deep_sleep  <= deep_ff && !busy;
    end
  end
endmodule
`default_nettype wire

// *** rtl/spi_flash_pkg.sv ***
`default_nettype none
package spi_flash_pkg;

  // ****************************************
  // array geometry and serial framing
  // ****************************************
  localparam int         PAGE_BYTES   = 256;
  localparam logic [7:0] PAGE_LAST    = 8'hff;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] BYTE_ONE     = 3'h1;
  localparam logic [2:0] BYTE_ADDR_LO = 3'h3;
  localparam logic [2:0] BYTE_DATA    = 3'h4;
  localparam logic [2:0] BYTE_FULL    = 3'h5;
  localparam logic [4:0] BITS_BYTE    = 5'h08;
  localparam logic [4:0] BITS_ADDR    = 5'h18;

  // ****************************************
  // command codes (arbitrary values)
  // ****************************************
  localparam logic [7:0] write_latch_set_cmd = 8'h21;
  localparam logic [7:0] page_write_cmd      = 8'h22;
  localparam logic [7:0] page_program_cmd    = 8'h23;
  localparam logic [7:0] read_status_cmd     = 8'h24;
  localparam logic [7:0] read_data_cmd       = 8'h25;
  localparam logic [7:0] deep_sleep_cmd      = 8'h26;
  localparam logic [7:0] wake_cmd            = 8'h27;

  // ****************************************
  // status byte fields
  // ****************************************
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_LATCH_BIT = 1;

  // ****************************************
  // controller register map (byte offsets)
  // ****************************************
  localparam logic [4:0] REG_START  = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_DATA   = 5'h08;
  localparam logic [4:0] REG_END    = 5'h0c;
  localparam logic [4:0] REG_CONFIG = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam int         CFG_CPOL_BIT  = 0;
  localparam int         CFG_RESET_BIT = 1;
  localparam int         STS_SEL_BIT   = 2;

  typedef enum logic [4:0] {
    CYC_IDLE  = 5'b00001,
    CYC_MERGE = 5'b00010,
    CYC_ERASE = 5'b00100,
    CYC_PROG  = 5'b01000,
    CYC_WAIT  = 5'b10000
  } cycle_state_t;

  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_SEL   = 6'b000010,
    H_LOW   = 6'b000100,
    H_HIGH  = 6'b001000,
    H_DESEL = 6'b010000,
    H_ACK   = 6'b100000
  } host_state_t;

endpackage
`default_nettype wire

// *** rtl/flash_spi_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface flash_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic reset_n;
  logic miso_out;
  logic miso_oe;
  wire  miso_line;

  // board pull-up holds the data-out line high while nobody drives it
  assign miso_line = miso_oe ? miso_out : 1'b1;

  modport device (input sclk, input cs_n, input mosi, input reset_n, output miso_out, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, output reset_n, input miso_line);
endinterface
`default_nettype wire

// *** rtl/pin_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  // pins
  input  wire logic [WIDTH-1:0] i_pin,
  // filtered level and edges
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] nxt_level;

  // a change counts only once the second and third stages agree
  assign agree     = ~(s2_ff ^ s3_ff);
  assign nxt_level = (agree & s3_ff) | (~agree & o_level);

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      s1_ff   <= RESET_VAL;
      s2_ff   <= RESET_VAL;
      s3_ff   <= RESET_VAL;
      o_level <= RESET_VAL;
      o_rise  <= '0;
      o_fall  <= '0;
    end else begin
      s1_ff   <= i_pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      o_level <= nxt_level;
      o_rise  <= nxt_level & ~o_level;
      o_fall  <= ~nxt_level & o_level;
    end
  end
endmodule
`default_nettype wire

// *** rtl/flash_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
  parameter int SCK_HALF = 8
) (
  // link
  flash_spi_if.host bus,
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // avalon-mm slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest
);
  import spi_flash_pkg::*;

  // data-out is sampled at the end of the high phase, after sync delay
  if (SCK_HALF < 6 || SCK_HALF > 65535) begin : g_bad_half
    $error("SCK_HALF must be 6 to 65535");
  end

  logic miso_l;

  pin_sync3 #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (bus.miso_line),
    .o_level   (miso_l),
    .o_rise    (),
    .o_fall    ()
  );

  host_state_t state_ff;
  logic [15:0] cnt_ff;
  logic [4:0]  bits_ff;
  logic [23:0] tx_ff;
  logic [7:0]  rx_ff;
  logic [1:0]  cfg_ff;
  logic        sclk_ff;
  logic        cs_n_ff;
  logic        mosi_ff;
  logic        req;
  logic        half_done;

  assign req       = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  assign half_done = cnt_ff == 16'(SCK_HALF - 1);

  // ****************************************
  // transfer engine
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_ff          <= H_IDLE;
      cnt_ff            <= '0;
      bits_ff           <= '0;
      cfg_ff            <= '0;
      sclk_ff           <= 1'b0;
      cs_n_ff           <= 1'b1;
      mosi_ff           <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else begin
      case (state_ff)
        H_IDLE: begin
          cnt_ff <= '0;
          if (cs_n_ff) begin
            sclk_ff <= cfg_ff[CFG_CPOL_BIT];
          end
          if (req && i_avs_write && i_avs_address == REG_START) begin
            cs_n_ff  <= 1'b0;
            tx_ff    <= {i_avs_writedata[7:0], 16'h0};
            bits_ff  <= BITS_BYTE;
            state_ff <= H_SEL;
          end else if (req && i_avs_write && i_avs_address == REG_ADDR) begin
            tx_ff    <= i_avs_writedata[23:0];
            bits_ff  <= BITS_ADDR;
            state_ff <= H_SEL;
          end else if (req && i_avs_address == REG_DATA) begin
            // one byte per access; the cs stays low between them
            tx_ff    <= {(i_avs_write ? i_avs_writedata[7:0] : 8'h0), 16'h0};
            bits_ff  <= BITS_BYTE;
            state_ff <= H_SEL;
          end else if (req && i_avs_write && i_avs_address == REG_END) begin
            cs_n_ff  <= 1'b1;
            state_ff <= H_DESEL;
          end else if (req) begin
            if (i_avs_write && i_avs_address == REG_CONFIG) begin
              cfg_ff <= i_avs_writedata[1:0];
            end
            o_avs_readdata <= '0;
            if (i_avs_read && i_avs_address == REG_CONFIG) begin
              o_avs_readdata[1:0] <= cfg_ff;
            end else if (i_avs_read && i_avs_address == REG_STATUS) begin
              o_avs_readdata[1:0]         <= cfg_ff;
              o_avs_readdata[STS_SEL_BIT] <= !cs_n_ff;
            end
            o_avs_waitrequest <= 1'b0;
            state_ff          <= H_ACK;
          end
        end
        H_SEL: begin
          cnt_ff <= cnt_ff + 16'h1;
          if (half_done) begin
            cnt_ff   <= '0;
            sclk_ff  <= 1'b0;
            mosi_ff  <= tx_ff[23];
            state_ff <= H_LOW;
          end
        end
        H_LOW: begin
          cnt_ff <= cnt_ff + 16'h1;
          if (half_done) begin
            cnt_ff   <= '0;
            sclk_ff  <= 1'b1;
            state_ff <= H_HIGH;
          end
        end
        H_HIGH: begin
          cnt_ff <= cnt_ff + 16'h1;
          if (half_done) begin
            cnt_ff  <= '0;
            rx_ff   <= {rx_ff[6:0], miso_l};
            tx_ff   <= {tx_ff[22:0], 1'b0};
            bits_ff <= bits_ff - 5'h1;
            if (bits_ff == 5'h1) begin
              sclk_ff           <= cfg_ff[CFG_CPOL_BIT];
              o_avs_readdata    <= {24'h0, rx_ff[6:0], miso_l};
              o_avs_waitrequest <= 1'b0;
              state_ff          <= H_ACK;
            end else begin
              sclk_ff  <= 1'b0;
              mosi_ff  <= tx_ff[22];
              state_ff <= H_LOW;
            end
          end
        end
        H_DESEL: begin
          cnt_ff  <= cnt_ff + 16'h1;
          sclk_ff <= cfg_ff[CFG_CPOL_BIT];
          if (half_done) begin
            o_avs_readdata    <= '0;
            o_avs_waitrequest <= 1'b0;
            state_ff          <= H_ACK;
          end
        end
        H_ACK: begin
          o_avs_waitrequest <= 1'b1;
          state_ff          <= H_IDLE;
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.sclk    = sclk_ff;
  assign bus.cs_n    = cs_n_ff;
  assign bus.mosi    = mosi_ff;
  assign bus.reset_n = cfg_ff[CFG_RESET_BIT];
endmodule
`default_nettype wire

// *** test/flash_link_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_link_properties (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic reset_n,
  input wire logic miso_out,
  input wire logic miso_oe
);
  // ****************************************
  // link timing, figures for a half period of 8 clocks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  idle_sel_a: assert property ($fell(cs_n) |-> $stable(sclk) [*8])
    else $error("serial clock moved too soon after select");
  half_period_a: assert property (!cs_n && $changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  desel_min_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("deselect gap too short");
  desel_hiz_a: assert property (cs_n [*8] |-> !miso_oe)
    else $error("data out driven while deselected");
  pin_reset_hiz_a: assert property (!reset_n [*8] |-> !miso_oe)
    else $error("data out driven while memory held in reset");
  oe_select_a: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("data out enabled without select");
  // device launches data only in the low phase, so the host sees it settled
  miso_edge_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_out) |-> !sclk)
    else $error("data out changed while serial clock high");
  mosi_edge_a: assert property (!cs_n && $past(!cs_n) && $changed(mosi) |-> !sclk)
    else $error("data in changed while serial clock high");
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, g, w); end end
module tb;
  import spi_flash_pkg::*;
  typedef struct packed {
    logic        cpol;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  data;
    logic [7:0]  want;
  } case_t;
  logic        i_sys_clk;
  logic        i_reset_n;
  logic [4:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        o_busy, o_write_latch, o_active, o_standby, o_deep_sleep;
  logic [31:0] rd;
  logic [7:0]  got;
  logic        seen_busy;
  int          num_errors;
  int          comparisons;
  // program ands into erased byte, page write replaces it, both clock modes
  case_t       rows [4] = '{'{1'b0, page_program_cmd, 24'h000010, 8'h5a, 8'h5a},
                            '{1'b1, page_program_cmd, 24'h000010, 8'h0f, 8'h0a},
                            '{1'b1, page_write_cmd, 24'h000010, 8'hf0, 8'hf0},
                            '{1'b0, page_write_cmd, 24'h0000ff, 8'h33, 8'h33}};

  flash_spi_if link ();
  flash_host #(.SCK_HALF(8)) flash_host_inst (.bus(link), .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
  flash_dev #(.NUM_PAGES(4), .CYCLE_WAIT(4)) flash_dev_inst (.bus(link), .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .o_busy(o_busy), .o_write_latch(o_write_latch), .o_active(o_active),
    .o_standby(o_standby), .o_deep_sleep(o_deep_sleep));
  flash_link_properties flash_link_properties_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .reset_n(link.reset_n),
    .miso_out(link.miso_out), .miso_oe(link.miso_oe));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge i_sys_clk);
    i_avs_address   <= a;
    i_avs_read      <= !wr;
    i_avs_write     <= wr;
    i_avs_writedata <= d;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 4000);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (n >= 4000) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // kind 0 command only, 1 address and byte out, 2 address and byte in, 3 byte in
  task automatic seq(input logic [7:0] c, input logic [23:0] a, input int kind, input logic [7:0] d);
    av(1'b1, REG_START, {24'h0, c});
    if (kind == 1 || kind == 2) av(1'b1, REG_ADDR, {8'h0, a});
    if (kind != 0) av(kind == 1, REG_DATA, {24'h0, d});
    got = rd[7:0];
    av(1'b1, REG_END, 32'h0);
  endtask

  task automatic wait_idle();
    int n;
    seen_busy = 1'b0;
    n = 0;
    do begin
      seq(read_status_cmd, 24'h0, 3, 8'h0);
      if (got[STAT_BUSY_BIT] === 1'b1) seen_busy = 1'b1;
      n++;
    end while (got[STAT_BUSY_BIT] !== 1'b0 && n < 40);
    if (n >= 40) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_reset_n       = 1'b0;
    i_avs_address   = 5'h00;
    i_avs_read      = 1'b0;
    i_avs_write     = 1'b0;
    i_avs_writedata = 32'h0;
    num_errors      = 0;
    comparisons     = 0;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    foreach (rows[i]) begin
      av(1'b1, REG_CONFIG, {30'h0, 1'b1, rows[i].cpol});
      seq(write_latch_set_cmd, 24'h0, 0, 8'h0);
      seq(rows[i].op, rows[i].addr, 1, rows[i].data);
      `CHK({o_busy, o_active, o_standby}, 3'h6)
      wait_idle();
      `CHK({seen_busy, got[STAT_LATCH_BIT], o_standby, o_active}, 4'ha)
      seq(read_data_cmd, rows[i].addr, 2, 8'h0);
      `CHK(got, rows[i].want)
    end
    // untouched byte of the page survives the later page write
    seq(read_data_cmd, 24'h000010, 2, 8'h0);
    `CHK(got, 8'hf0)
    // no latch, no change
    seq(page_write_cmd, 24'h000010, 1, 8'h00);
    `CHK({o_busy, o_write_latch}, 2'h0)
    // deep power-down swallows latch set and page write
    seq(deep_sleep_cmd, 24'h0, 0, 8'h0);
    seq(write_latch_set_cmd, 24'h0, 0, 8'h0);
    seq(page_write_cmd, 24'h000010, 1, 8'h00);
    `CHK({o_deep_sleep, o_busy, o_write_latch}, 3'h4)
    seq(wake_cmd, 24'h0, 0, 8'h0);
    seq(read_data_cmd, 24'h000010, 2, 8'h0);
    `CHK({o_deep_sleep, got}, 9'h0f0)
    // pin reset drops the latch; long enough for the pin synchroniser
    seq(write_latch_set_cmd, 24'h0, 0, 8'h0);
    `CHK(o_write_latch, 1'b1)
    av(1'b1, REG_CONFIG, 32'h0);
    repeat (10) @(posedge i_sys_clk);
    av(1'b1, REG_CONFIG, 32'h2);
    `CHK(o_write_latch, 1'b0)
    // array survives the pin reset, a system reset blanks it
    seq(read_data_cmd, 24'h000010, 2, 8'h0);
    `CHK(got, 8'hf0)
    i_reset_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    `CHK({o_busy, o_write_latch, o_active, o_standby, o_deep_sleep}, 5'h02)
    av(1'b1, REG_CONFIG, 32'h2);
    seq(read_data_cmd, 24'h000010, 2, 8'h0);
    `CHK(got, 8'hff)
    // host status shows the select held between accesses
    av(1'b1, REG_START, {24'h0, read_status_cmd});
    av(1'b0, REG_STATUS, 32'h0);
    `CHK(rd, 32'h6)
    av(1'b1, REG_END, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
